/* design/sar_adc_defines.vh */
// constants for the successive-approximation converter control block
// assumes an 8-bit wishbone register view in the low bits of a 32-bit bus
`ifndef SAR_ADC_DEFINES_VH
`define SAR_ADC_DEFINES_VH

// ==========================================
// register byte addresses
`define REG_RESULT_HIGH   4'h0
`define REG_RESULT_LOW    4'h4
`define REG_CONV_CONTROL  4'h8
`define REG_PORT_CONFIG   4'hC
`define REG_IRQ_STATUS    8'h10
`define REG_IRQ_MASK      8'h14

// ==========================================
// field positions
`define CTRL_MODULE_ON    0
`define CTRL_GO           2
`define CFG_REF_SELECT    0
`define CFG_FORMAT        5
`define CTRL_WMASK        8'hF1
`define CFG_WMASK         8'hEF
`define CTRL_RESET        8'h00
`define CFG_RESET         8'h00

// ==========================================
// timing
`define DIV_8             7'h07
`define DIV_32            7'h1F
`define DIV_64            7'h3F
`define RC_DIV            7'h0F
`define ACQ_TICKS         4'h2
`define RESULT_BITS       10

`endif

/* design/conv_clock_gen.v */
// conversion tick generator: divided system clock or internal rc tick
// assumes rc_tick is a one-cycle pulse synchronous to clk
`timescale 1ns/10ps
`default_nettype none
`include "sar_adc_defines.vh"

module conv_clock_gen (
   // clock and reset
   input  wire       clk,
   input  wire       reset_n,
   // control
   input  wire       run,
   input  wire [1:0] clock_select,
   input  wire       rc_tick,
   // tick out
   output reg        tick
);
   reg [6:0] count;
   reg [6:0] limit;

   // ==========================================
   // divider limit per select code
   always @* begin
      case (clock_select)
         2'b00:   limit = `DIV_8;
         2'b01:   limit = `DIV_32;
         2'b10:   limit = `DIV_64;
         default: limit = `DIV_8;
      endcase
   end

   // counter clears when idle so each conversion on a divided clock starts with a full period
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         count <= 7'h00;
         tick  <= 1'b0;
      end else if (!run) begin
         count <= 7'h00;
         tick  <= 1'b0;
      end else if (clock_select == 2'b11) begin
         tick  <= rc_tick;
      end else if (count == limit) begin
         count <= 7'h00;
         tick  <= 1'b1;
      end else begin
         count <= count + 7'h01;
         tick  <= 1'b0;
      end
   end
endmodule
`default_nettype wire

/* design/sar_engine.v */
// successive-approximation search over the held comparator level
// assumes comparator answers within one tick of dac_code change
`timescale 1ns/10ps
`default_nettype none
`include "sar_adc_defines.vh"

module sar_engine (
   // clock and reset
   input  wire       clk,
   input  wire       reset_n,
   // control
   input  wire       start,
   input  wire       tick,
   input  wire       compare_high,
   // results
   output reg  [9:0] dac_code,
   output reg  [9:0] result,
   output reg        busy,
   output reg        done
);
   reg [9:0] bit_mask;

   // ==========================================
   // trial bit kept when held level is above dac code
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         dac_code <= 10'h000;
         bit_mask <= 10'h000;
         result   <= 10'h000;
         busy     <= 1'b0;
         done     <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start && !busy) begin
            busy     <= 1'b1;
            bit_mask <= 10'h200;
            dac_code <= 10'h200;
         end else if (busy && tick) begin
            if (bit_mask == 10'h001) begin
               result <= compare_high ? dac_code : (dac_code & ~bit_mask);
               busy   <= 1'b0;
               done   <= 1'b1;
            end else begin
               dac_code <= (compare_high ? dac_code : (dac_code & ~bit_mask)) | (bit_mask >> 1);
               bit_mask <= bit_mask >> 1;
            end
         end
      end
   end
endmodule
`default_nettype wire

/* design/sar_adc_control.v */
// wishbone register front end and sequencer of the converter
// assumes analog mux, hold switch and comparator outside; classic wishbone
`timescale 1ns/10ps
`default_nettype none
`include "sar_adc_defines.vh"

module sar_adc_control #(
   parameter SIXTEEN_CHANNELS = 1
) (
   // system
   input  wire        clk,
   input  wire        reset_n,
   // wishbone slave
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [7:0]  wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o,
   // analog front end
   input  wire        compare_high,
   input  wire        rc_tick,
   output reg  [3:0]  channel_select,
   output reg         sample_hold,
   output reg         module_on,
   output reg         ref_from_pins,
   output reg  [15:0] pin_analog_enable,
   output reg  [9:0]  dac_code,
   // interrupt
   output reg         irq
);
   // ==========================================
   // registers
   reg  [7:0] conversion_control;
   reg  [7:0] port_function_config;
   reg  [9:0] result_value;
   reg        conversion_done_flag;
   reg        irq_mask;
   reg  [1:0] acq_count;
   reg        start_req;

   wire [9:0] engine_code;
   wire [9:0] engine_result;
   wire       engine_busy;
   wire       engine_done;
   wire       tick;
   wire       access;
   wire       wr_lane0;
   wire       channel_ok;
   reg  [7:0] result_high_byte;
   reg  [7:0] result_low_byte;
   reg  [7:0] read_byte;
   reg  [15:0] next_pins;

   assign access   = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr_lane0 = access && wb_we_i && wb_sel_i[0];
   // on the small part a go is refused while the stored channel code is reserved; the code written with the go is not checked
   assign channel_ok = SIXTEEN_CHANNELS || (conversion_control[7:6] != 2'b11);

   // ==========================================
   // conversion tick and search engine
   conv_clock_gen u_clock (
      .clk          (clk),
      .reset_n      (reset_n),
      .run          (engine_busy),
      .clock_select (port_function_config[7:6]),
      .rc_tick      (rc_tick),
      .tick         (tick)
   );

   sar_engine u_engine (
      .clk          (clk),
      .reset_n      (reset_n),
      .start        (start_req),
      .tick         (tick),
      .compare_high (compare_high),
      .dac_code     (engine_code),
      .result       (engine_result),
      .busy         (engine_busy),
      .done         (engine_done)
   );

   // ==========================================
   // result justification
   always @* begin
      if (port_function_config[`CFG_FORMAT]) begin
         result_high_byte = {6'h00, result_value[9:8]};
         result_low_byte  = result_value[7:0];
      end else begin
         result_high_byte = result_value[9:2];
         result_low_byte  = {result_value[1:0], 6'h00};
      end
   end

   // pin map: config steps 1 to 6 each turn one more pin per bank digital; step 7 turns every pin digital
   always @* begin : pin_map
      integer i;
      next_pins = 16'h0000;
      for (i = 0; i < 8; i = i + 1) begin
         next_pins[i]     = (i < 8 - port_function_config[3:1]) || (port_function_config[3:1] == 3'h0);
         next_pins[i + 8] = next_pins[i];
      end
      if (port_function_config[3:1] == 3'h7)
         next_pins = 16'h0000;
   end

   // read mux; only the four documented registers plus irq pair
   always @* begin
      case (wb_adr_i)
         {4'h0, `REG_RESULT_HIGH}:  read_byte = result_high_byte;
         {4'h0, `REG_RESULT_LOW}:   read_byte = result_low_byte;
         {4'h0, `REG_CONV_CONTROL}: read_byte = {conversion_control[7:3], engine_busy | start_req,
                                                1'b0, conversion_control[0]};
         {4'h0, `REG_PORT_CONFIG}:  read_byte = port_function_config;
         `REG_IRQ_STATUS:           read_byte = {7'h00, conversion_done_flag};
         `REG_IRQ_MASK:             read_byte = {7'h00, irq_mask};
         default:                   read_byte = 8'h00;
      endcase
   end

   // ==========================================
   // bus slave: answers one cycle after the request, unmapped reads zero
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= access;
         wb_dat_o <= access ? {24'h000000, read_byte} : 32'h0000_0000;
      end
   end

   // ==========================================
   // control and configuration registers
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         conversion_control   <= `CTRL_RESET;
         port_function_config <= `CFG_RESET;
         irq_mask             <= 1'b0;
      end else if (wr_lane0) begin
         case (wb_adr_i)
            {4'h0, `REG_CONV_CONTROL}: conversion_control   <= wb_dat_i[7:0] & `CTRL_WMASK;
            {4'h0, `REG_PORT_CONFIG}:  port_function_config <= wb_dat_i[7:0] & `CFG_WMASK;
            `REG_IRQ_MASK:             irq_mask             <= wb_dat_i[0];
            default:                   irq_mask             <= irq_mask;
         endcase
      end
   end

   // ==========================================
   // start: acquisition hold-off, then search
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         start_req   <= 1'b0;
         acq_count   <= 2'b00;
         sample_hold <= 1'b0;
      end else begin
         if (wr_lane0 && wb_adr_i == {4'h0, `REG_CONV_CONTROL} && wb_dat_i[`CTRL_GO]
             && wb_dat_i[`CTRL_MODULE_ON] && !engine_busy && !start_req && channel_ok) begin
            start_req <= 1'b1;
            acq_count <= 2'b00;
         end else if (start_req) begin
            acq_count <= acq_count + 2'b01;
            if (acq_count == `ACQ_TICKS - 4'h1)
               start_req <= 1'b0;
         end
         // hold capacitor isolated from the mux while converting
         sample_hold <= engine_busy | (start_req && acq_count != 2'b00);
      end
   end

   // ==========================================
   // result capture, flag and pin outputs
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         result_value         <= 10'h000;
         conversion_done_flag <= 1'b0;
         irq                  <= 1'b0;
         channel_select       <= 4'h0;
         module_on            <= 1'b0;
         ref_from_pins        <= 1'b0;
         pin_analog_enable    <= 16'h0000;
         dac_code             <= 10'h000;
      end else begin
         if (engine_done)
            result_value <= engine_result;
         // set wins over the clear on read
         if (engine_done)
            conversion_done_flag <= 1'b1;
         else if (access && !wb_we_i && wb_adr_i == `REG_IRQ_STATUS)
            conversion_done_flag <= 1'b0;
         irq               <= (conversion_done_flag | engine_done) & irq_mask;
         channel_select    <= conversion_control[7:4];
         module_on         <= conversion_control[`CTRL_MODULE_ON];
         ref_from_pins     <= port_function_config[`CFG_REF_SELECT];
         pin_analog_enable <= SIXTEEN_CHANNELS ? next_pins : (next_pins & 16'h0FFF);
         dac_code          <= engine_code;
      end
   end
endmodule
`default_nettype wire

/* tb/analog_front_model.sv */
// hold capacitor, comparator and rc oscillator beside the converter
// assumes sample_hold high while the selected input is isolated
`timescale 1ns/10ps
`default_nettype none
module analog_front_model (
   // system
   input  wire logic       clk,
   input  wire logic       reset_n,
   // from the converter
   input  wire logic [3:0] channel_select,
   input  wire logic       sample_hold,
   input  wire logic [9:0] dac_code,
   // to the converter
   output wire logic       compare_high,
   output wire logic       rc_tick
);
   logic [9:0] held;
   logic [2:0] rc_cnt;
   logic       noise;
   // capacitor tracks the chosen input until hold closes
   always @(posedge clk) begin
      if (!sample_hold)
         held <= {channel_select, ~channel_select, 2'h2};
   end
   // only a held level is judged; an open input gives noise
   assign compare_high = sample_hold ? (held >= dac_code) : noise;
   // free running rc source, one pulse every five clocks
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rc_cnt <= 3'h0;
         noise  <= 1'b0;
      end else begin
         rc_cnt <= (rc_cnt == 3'h4) ? 3'h0 : rc_cnt + 3'h1;
         noise  <= ~noise;
      end
   end
   assign rc_tick = (rc_cnt == 3'h4);
endmodule
`default_nettype wire

/* tb/sar_adc_properties.sv */
// port checker of the converter control block
// assumes one clock domain; bound into the block below
`timescale 1ns/10ps
`default_nettype none
module sar_adc_checker (
   // system
   input wire logic        clk,
   input wire logic        reset_n,
   // bus
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   // front end
   input wire logic [3:0]  channel_select,
   input wire logic        sample_hold,
   input wire logic        ref_from_pins,
   input wire logic [15:0] pin_analog_enable,
   input wire logic        irq
);
   wire logic take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire logic wr   = take & wb_we_i & wb_sel_i[0];
   logic [7:0] ctl;
   logic [7:0] cfg;
   logic       msk;
   wire logic [7:0] pb = (cfg[3:1] == 3'h7) ? 8'h00 : 8'hFF >> cfg[3:1];
   // shadow of software writes, taken at the request edge
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ctl <= 8'h00;
         cfg <= 8'h00;
         msk <= 1'b0;
      end else if (wr) begin
         if (wb_adr_i == 8'h08)
            ctl <= wb_dat_i[7:0];
         if (wb_adr_i == 8'h0C)
            cfg <= wb_dat_i[7:0];
         if (wb_adr_i == 8'h14)
            msk <= wb_dat_i[0];
      end
   end
   default clocking dc @(posedge clk); endclocking
   default disable iff (!reset_n);
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack too long");
   a_ack_answer: assert property (take |=> wb_ack_o)
      else $error("no ack next cycle");
   a_data_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("data outside ack");
   a_unmapped_zero: assert property (take && !wb_we_i && wb_adr_i > 8'h14 |=> wb_dat_o == 32'h0)
      else $error("unmapped read not zero");
   a_result_pad: assert property (take && !wb_we_i && wb_adr_i == 8'h00 && cfg[5] |=> wb_dat_o[7:2] == 6'h0)
      else $error("high byte pad not zero");
   a_channel_follow: assert property (wr && wb_adr_i == 8'h08 |-> ##3 channel_select == ctl[7:4])
      else $error("channel not applied");
   a_ref_pins: assert property (wr && wb_adr_i == 8'h0C |-> ##3 ref_from_pins == cfg[0] && pin_analog_enable == {pb, pb})
      else $error("pin setup not applied");
   a_irq_masked: assert property (irq |-> msk || $past(msk) || $past(msk, 2))
      else $error("irq while masked");
   cover property (wr && wb_adr_i == 8'h08 && wb_dat_i[2]);
   cover property ($fell(sample_hold));
   cover property ($rose(irq));
endmodule
bind sar_adc_control sar_adc_checker chk (.clk, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
   .wb_dat_i, .wb_dat_o, .wb_ack_o, .channel_select, .sample_hold, .ref_from_pins, .pin_analog_enable, .irq);
`default_nettype wire

/* tb/testbench.sv */
// self-checking bench of the converter control block
// assumes the block, analog model and checker are compiled with it
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic        clk, reset_n, cyc, stb, we, ack, compare_high, rc_tick;
   logic        sample_hold, module_on, ref_from_pins, irq;
   logic [7:0]  adr;
   logic [3:0]  sel, channel_select, c;
   logic [31:0] wdat, rdat, q;
   logic [15:0] pin_analog_enable;
   logic [9:0]  dac_code, h;
   int          errors, tests_run, n, k;
   sar_adc_control #(.SIXTEEN_CHANNELS(1)) DUT (.clk, .reset_n, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .compare_high, .rc_tick,
      .channel_select, .sample_hold, .module_on, .ref_from_pins, .pin_analog_enable, .dac_code, .irq);
   analog_front_model afe (.clk, .reset_n, .channel_select, .sample_hold, .dac_code, .compare_high, .rc_tick);
   // ==========================================
   // tasks
   task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         errors++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one classic cycle; held until ack is sampled, data taken there
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      int t;
      @(posedge clk);
      {cyc, stb, we, adr, wdat} <= {2'h3, w, a, 24'h000000, d};
      t = 0;
      do begin
         @(posedge clk);
         t++;
      end while (ack !== 1'b1 && t < 50);
      q = rdat;
      {cyc, stb, we} <= 3'h0;
      if (t >= 50)
         check("ack", 32'h1, 32'h0);
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e, input string nm);
      bus(1'b0, a, 8'h00);
      check(nm, e, q);
   endtask
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // ==========================================
   // clock and watchdog; the run needs far fewer than 20000 clocks
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      #800000;
      errors++;
      final_report;
   end
   // ==========================================
   // main sequence
   initial begin
      {reset_n, cyc, stb, we, adr, sel, wdat} = '0;
      errors = 0;
      tests_run = 0;
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      sel <= 4'hE;
      rc(8'h08, 32'h0, "control reset");
      rc(8'h0C, 32'h0, "config reset");
      bus(1'b1, 8'h08, 8'h01);
      sel <= 4'hF;
      rc(8'h08, 32'h0, "lane off");
      bus(1'b1, 8'h20, 8'hFF);
      rc(8'h20, 32'h0, "unmapped");
      bus(1'b1, 8'h08, 8'h04);
      rc(8'h08, 32'h0, "start while off");
      check("power", 32'h0, {31'h0, module_on});
      $display("test access done");
      // every pin pattern of the analog config field
      for (n = 0; n < 8; n++) begin
         bus(1'b1, 8'h0C, 8'(n * 2));
         @(posedge clk);
         check("pins", (n == 7) ? 32'h0 : {16'h0, 8'hFF >> n, 8'hFF >> n}, {16'h0, pin_analog_enable});
      end
      $display("test pins done");
      // one conversion per clock source, both formats and references
      for (n = 0; n < 4; n++) begin
         c = 4'(n * 5);
         h = {c, ~c, 2'h2};
         bus(1'b1, 8'h14, {7'h0, n[0]});
         bus(1'b1, 8'h0C, {n[1:0], n[0], 4'h8, n[1]});
         rc(8'h0C, {24'h0, n[1:0], n[0], 4'h0, n[1]}, "config");
         check("reference", {31'h0, n[1]}, {31'h0, ref_from_pins});
         bus(1'b1, 8'h08, {c, 4'h5});
         repeat (4) @(posedge clk);
         check("power on", {27'h0, c, 1'b1}, {27'h0, channel_select, module_on});
         rc(8'h08, {24'h0, c, 4'h5}, "busy");
         k = 0;
         do begin
            bus(1'b0, 8'h08, 8'h00);
            k++;
         end while (q[2] !== 1'b0 && k < 2000);
         check("done", {24'h0, c, 4'h1}, q);
         @(posedge clk);
         check("irq", {31'h0, n[0]}, {31'h0, irq});
         rc(8'h00, n[0] ? {30'h0, h[9:8]} : {24'h0, h[9:2]}, "high");
         rc(8'h04, n[0] ? {24'h0, h[7:0]} : {24'h0, h[1:0], 6'h0}, "low");
         rc(8'h10, 32'h1, "flag set");
         rc(8'h10, 32'h0, "flag clear");
         check("irq off", 32'h0, {31'h0, irq});
         $display("test conversion %0d done", n);
      end
      final_report;
   end
endmodule
`default_nettype wire
